// ===== hdl/vts_pkg.sv
// Constants and types for the valve travel supervisor
// Functional notes
// - Travel decreases limited so a full stroke takes at least the closing time, capped at 400 s; 0 disables.
// - Travel increases limited so a full stroke takes at least the opening time, capped at 400 s; 0 disables.
// - Polling address accepted 0..15 under revision 5, 0..63 under revision 7.
// - Return to In Service only by the same master type that took it out.
// - Set point passes a first-order lag; zero time constant bypasses it.
// - Accumulate a travel change only when it exceeds the deadband; clearing zeroes it.
// - Deadband is re-centred on the travel captured at each increment; 0..100 percent.
// - Accumulator alert set above the alert point, cleared only once below it or on a synchronous clear.
// - Accumulator alert point accepted from zero up to four billion percent.
// - Four travel alerts set past their point, cleared after the deadband is recrossed.
// - Travel alert points and deadband accepted from -25 to 125 percent.
// - Beyond a cutoff the drive goes to full or zero and rate limits stop.
// - Deviation alert after deviation exceeds the point for longer than the deviation time.
// - Deviation time accepted 1..60 seconds, deviation point 0..100 percent.
// - Travel target clamped between the low and high travel limits.
// - Deviation is analog target minus ranged travel.
package vts_pkg;

   // Travel in hundredths of a percent
   typedef logic signed [15:0] vts_pct_t;

   typedef enum {st_in_service, st_out_of_service} vts_mode_t;

   localparam int       CLK_MHZ       = 50;
   localparam int       TICK_US       = 100;
   localparam int       TICK_CYC      = CLK_MHZ * TICK_US;
   localparam int       TICKS_PER_S   = 1000000 / TICK_US;

   localparam vts_pct_t PCT_ZERO      = 16'sh0000;
   localparam vts_pct_t PCT_FULL      = 16'sh2710;
   localparam vts_pct_t PCT_LO        = 16'shF63C;
   localparam vts_pct_t PCT_HI        = 16'sh30D4;
   localparam vts_pct_t PCT_ONE       = 16'sh0001;

   localparam logic [8:0]  STROKE_MAX    = 9'h190;
   localparam logic [5:0]  DEV_T_MIN     = 6'h01;
   localparam logic [5:0]  DEV_T_MAX     = 6'h3C;
   localparam logic [31:0] ACC_PT_MAX    = 32'hEE6B2800;
   localparam logic [39:0] ACC_SCALE     = 40'h0000000064;
   localparam logic [5:0]  ADDR_MAX_REV5 = 6'h0F;
   localparam logic [5:0]  ADDR_MAX_REV7 = 6'h3F;

   // Travel alert order: high, low, high-high, low-low; set bits watch the high side
   localparam logic [3:0]  TA_HI_SIDE    = 4'h5;

endpackage

// ===== hdl/vts_supervisor.sv
// Travel supervision: target conditioning, drive, accumulator and alerts
`timescale 1ns/100ps
module vts_supervisor #(
   parameter int TICK_CYCLES = vts_pkg::TICK_CYC
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              nrst,
   // Process values
   input  wire vts_pkg::vts_pct_t ranged_travel,
   input  wire vts_pkg::vts_pct_t analog_target,
   // Commands
   input  wire logic              sync_clr,
   input  wire logic              acc_clear,
   input  wire logic              addr_wr,
   input  wire logic [5:0]        addr_in,
   input  wire logic              hart_rev7,
   input  wire logic              oos_req,
   input  wire logic              ins_req,
   input  wire logic              req_secondary,
   // Conditioning setup
   input  wire logic [7:0]        lag_time_s,
   input  wire logic [8:0]        open_time_s,
   input  wire logic [8:0]        close_time_s,
   input  wire vts_pkg::vts_pct_t limit_lo,
   input  wire vts_pkg::vts_pct_t limit_hi,
   input  wire vts_pkg::vts_pct_t cutoff_lo,
   input  wire vts_pkg::vts_pct_t cutoff_hi,
   input  wire logic              zero_power_position,
   // Alert setup
   input  wire vts_pkg::vts_pct_t acc_deadband,
   input  wire logic [31:0]       acc_alert_pt,
   input  wire vts_pkg::vts_pct_t ta_hi_pt,
   input  wire vts_pkg::vts_pct_t ta_lo_pt,
   input  wire vts_pkg::vts_pct_t ta_hihi_pt,
   input  wire vts_pkg::vts_pct_t ta_lolo_pt,
   input  wire vts_pkg::vts_pct_t ta_deadband,
   input  wire vts_pkg::vts_pct_t dev_point,
   input  wire logic [5:0]        dev_time_s,
   // Drive and state
   output vts_pkg::vts_pct_t      drive_q,
   output logic                   cutoff_active_q,
   output logic                   in_service_q,
   output logic [5:0]             poll_addr_q,
   output logic                   point_to_point_q,
   // Accumulator and alerts
   output logic [39:0]            accum_q,
   output logic                   acc_alert_q,
   output logic [3:0]             travel_alert,
   output logic                   dev_alert_q
);

   localparam int TW = $clog2(TICK_CYCLES);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   function automatic vts_pkg::vts_pct_t sat(input vts_pkg::vts_pct_t v,
                                             input vts_pkg::vts_pct_t lo,
                                             input vts_pkg::vts_pct_t hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // Sample tick
   logic [TW-1:0] tick_cnt_q;
   logic          tick_q;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + TW'(1);
         tick_q     <= 1'b0;
      end
   end

   // Service mode and owning master type
   vts_pkg::vts_mode_t mode_q;
   logic               owner_q;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_q       <= vts_pkg::st_in_service;
         owner_q      <= 1'b0;
         in_service_q <= 1'b1;
      end else begin
         case (mode_q)
            vts_pkg::st_in_service: begin
               if (oos_req) begin
                  mode_q       <= vts_pkg::st_out_of_service;
                  owner_q      <= req_secondary;
                  in_service_q <= 1'b0;
               end
            end
            default: begin
               // A request from the other master type is ignored
               if (ins_req && req_secondary == owner_q) begin
                  mode_q       <= vts_pkg::st_in_service;
                  in_service_q <= 1'b1;
               end
            end
         endcase
      end
   end
   a_mode_owner: assert property ((mode_q == vts_pkg::st_out_of_service && ins_req
      && req_secondary != owner_q) |=> !in_service_q)
      else $error("wrong master type returned the device to service");

   // Polling address
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         poll_addr_q      <= 6'h00;
         point_to_point_q <= 1'b1;
      end else if (addr_wr && addr_in <= (hart_rev7 ? vts_pkg::ADDR_MAX_REV7
                                                    : vts_pkg::ADDR_MAX_REV5)) begin
         poll_addr_q      <= addr_in;
         point_to_point_q <= (addr_in == 6'h00);
      end
   end
   a_addr_range: assert property ((addr_wr && !hart_rev7 && addr_in > vts_pkg::ADDR_MAX_REV5)
      |=> poll_addr_q == $past(poll_addr_q))
      else $error("out of range polling address was taken");

   // Target clamp and set point lag
   vts_pkg::vts_pct_t  tgt;
   vts_pkg::vts_pct_t  filt_q;
   logic [23:0]        facc_q;
   logic signed [16:0] ferr;
   logic [16:0]        fmag;
   logic [23:0]        tau_ticks;
   logic [24:0]        facc_n;

   assign tgt       = sat(analog_target, limit_lo, limit_hi);
   assign ferr      = 17'(tgt) - 17'(filt_q);
   assign fmag      = ferr[16] ? 17'(-ferr) : 17'(ferr);
   assign tau_ticks = 24'(lag_time_s) * 24'(vts_pkg::TICKS_PER_S);
   assign facc_n    = 25'(facc_q) + 25'(fmag);

   // One count per tick at most: a large step under a short lag runs slower than the ideal curve
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         filt_q <= vts_pkg::PCT_ZERO;
         facc_q <= 24'h000000;
      end else if (tick_q && in_service_q) begin
         if (lag_time_s == 8'h00) begin
            filt_q <= tgt;
            facc_q <= 24'h000000;
         end else if (fmag == 17'h00000) begin
            facc_q <= 24'h000000;
         end else if (facc_n >= 25'(tau_ticks)) begin
            facc_q <= 24'(facc_n - 25'(tau_ticks));
            filt_q <= ferr[16] ? filt_q - vts_pkg::PCT_ONE : filt_q + vts_pkg::PCT_ONE;
         end else begin
            facc_q <= 24'(facc_n);
         end
      end
   end
   a_lag_bypass: assert property ((tick_q && in_service_q && lag_time_s == 8'h00)
      |=> filt_q == $past(tgt))
      else $error("zero lag did not pass the target through");
   a_target_clamp: assert property ((limit_lo <= limit_hi && tick_q && in_service_q
      && lag_time_s == 8'h00) |=> (filt_q >= $past(limit_lo) && filt_q <= $past(limit_hi)))
      else $error("target escaped the travel limits");

   // Opening and closing rate limits
   logic                cut_hi;
   logic                cut_lo;
   logic [8:0]          open_t;
   logic [8:0]          close_t;
   logic [8:0]          rate_t;
   logic [8:0]          rate_cnt_q;
   vts_pkg::vts_pct_t   lim_q;

   assign cut_hi  = ranged_travel > cutoff_hi;
   assign cut_lo  = ranged_travel < cutoff_lo;
   assign open_t  = (open_time_s > vts_pkg::STROKE_MAX) ? vts_pkg::STROKE_MAX : open_time_s;
   assign close_t = (close_time_s > vts_pkg::STROKE_MAX) ? vts_pkg::STROKE_MAX : close_time_s;
   assign rate_t  = (filt_q > lim_q) ? open_t : close_t;

   // One count every rate_t ticks: a full stroke of 10000 counts takes rate_t seconds
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lim_q      <= vts_pkg::PCT_ZERO;
         rate_cnt_q <= 9'h000;
      end else if (tick_q && in_service_q) begin
         if (cut_hi || cut_lo || rate_t == 9'h000 || filt_q == lim_q) begin
            lim_q      <= filt_q;
            rate_cnt_q <= 9'h000;
         end else if (rate_cnt_q + 9'h001 >= rate_t) begin
            rate_cnt_q <= 9'h000;
            lim_q      <= (filt_q > lim_q) ? lim_q + vts_pkg::PCT_ONE
                                           : lim_q - vts_pkg::PCT_ONE;
         end else begin
            rate_cnt_q <= rate_cnt_q + 9'h001;
         end
      end
   end
   a_open_rate: assert property ((tick_q && in_service_q && !cut_hi && !cut_lo
      && open_t != 9'h000 && filt_q > lim_q) |=> (lim_q - $past(lim_q)) <= vts_pkg::PCT_ONE)
      else $error("opening faster than the opening time allows");
   a_close_rate: assert property ((tick_q && in_service_q && !cut_hi && !cut_lo
      && close_t != 9'h000 && filt_q < lim_q) |=> ($past(lim_q) - lim_q) <= vts_pkg::PCT_ONE)
      else $error("closing faster than the closing time allows");

   // Drive with cutoffs; out of service the drive holds
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         drive_q         <= vts_pkg::PCT_ZERO;
         cutoff_active_q <= 1'b0;
      end else if (in_service_q) begin
         cutoff_active_q <= cut_hi || cut_lo;
         if (cut_hi) begin
            drive_q <= zero_power_position ? vts_pkg::PCT_ZERO : vts_pkg::PCT_FULL;
         end else if (cut_lo) begin
            drive_q <= zero_power_position ? vts_pkg::PCT_FULL : vts_pkg::PCT_ZERO;
         end else begin
            drive_q <= lim_q;
         end
      end
   end
   sequence s_hi_cut;
      in_service_q && cut_hi && !zero_power_position;
   endsequence
   sequence s_lo_cut;
      in_service_q && !cut_hi && cut_lo && !zero_power_position;
   endsequence
   a_cut_high: assert property (s_hi_cut |=> drive_q == vts_pkg::PCT_FULL)
      else $error("high cutoff did not force full drive");
   a_cut_low: assert property (s_lo_cut |=> drive_q == vts_pkg::PCT_ZERO)
      else $error("low cutoff did not force zero drive");

   // Travel accumulator
   vts_pkg::vts_pct_t  acc_ref_q;
   vts_pkg::vts_pct_t  acc_db;
   logic signed [16:0] adiff;
   logic [16:0]        amag;
   logic               acc_step;
   logic [39:0]        acc_pt;

   assign acc_db   = sat(acc_deadband, vts_pkg::PCT_ZERO, vts_pkg::PCT_FULL);
   assign adiff    = 17'(ranged_travel) - 17'(acc_ref_q);
   assign amag     = adiff[16] ? 17'(-adiff) : 17'(adiff);
   assign acc_step = tick_q && (amag > 17'(acc_db));
   assign acc_pt   = 40'((acc_alert_pt > vts_pkg::ACC_PT_MAX) ? vts_pkg::ACC_PT_MAX
                                                              : acc_alert_pt) * vts_pkg::ACC_SCALE;

   // A step in the clearing cycle is kept on top of zero
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         accum_q   <= 40'h0000000000;
         acc_ref_q <= vts_pkg::PCT_ZERO;
      end else if (acc_step) begin
         accum_q   <= (acc_clear ? 40'h0000000000 : accum_q) + 40'(amag);
         acc_ref_q <= ranged_travel;
      end else if (acc_clear) begin
         accum_q   <= 40'h0000000000;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         acc_alert_q <= 1'b0;
      end else if (sync_clr) begin
         acc_alert_q <= 1'b0;
      end else if (accum_q > acc_pt) begin
         acc_alert_q <= 1'b1;
      end else if (accum_q < acc_pt) begin
         acc_alert_q <= 1'b0;
      end
   end
   a_acc_deadband: assert property ((tick_q && amag <= 17'(acc_db) && !acc_clear)
      |=> accum_q == $past(accum_q))
      else $error("accumulated a change inside the deadband");
   a_acc_ref: assert property (acc_step |=> acc_ref_q == $past(ranged_travel))
      else $error("deadband not re-centred on the captured travel");
   a_acc_alert: assert property ((accum_q > acc_pt && !sync_clr) |=> acc_alert_q)
      else $error("accumulator alert missing above its point");

   // Travel alerts
   vts_pkg::vts_pct_t ta_pt [4];
   vts_pkg::vts_pct_t ta_db;

   assign ta_pt[0] = sat(ta_hi_pt, vts_pkg::PCT_LO, vts_pkg::PCT_HI);
   assign ta_pt[1] = sat(ta_lo_pt, vts_pkg::PCT_LO, vts_pkg::PCT_HI);
   assign ta_pt[2] = sat(ta_hihi_pt, vts_pkg::PCT_LO, vts_pkg::PCT_HI);
   assign ta_pt[3] = sat(ta_lolo_pt, vts_pkg::PCT_LO, vts_pkg::PCT_HI);
   assign ta_db    = sat(ta_deadband, vts_pkg::PCT_LO, vts_pkg::PCT_HI);

   for (genvar i = 0; i < 4; i++) begin : g_ta
      logic signed [17:0] clr_lvl;
      logic               hit_q;

      assign clr_lvl = vts_pkg::TA_HI_SIDE[i] ? 18'(ta_pt[i]) - 18'(ta_db)
                                              : 18'(ta_pt[i]) + 18'(ta_db);
      assign travel_alert[i] = hit_q;

      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            hit_q <= 1'b0;
         end else if (sync_clr) begin
            hit_q <= 1'b0;
         end else if (tick_q) begin
            if (vts_pkg::TA_HI_SIDE[i] ? ranged_travel > ta_pt[i] : ranged_travel < ta_pt[i]) begin
               hit_q <= 1'b1;
            end else if (vts_pkg::TA_HI_SIDE[i] ? 18'(ranged_travel) < clr_lvl
                                                : 18'(ranged_travel) > clr_lvl) begin
               hit_q <= 1'b0;
            end
         end
      end
   end
   a_ta_high: assert property ((tick_q && !sync_clr && ranged_travel > ta_pt[0])
      |=> travel_alert[0])
      else $error("high travel alert missing");
   a_ta_hold: assert property ((travel_alert[1] && !sync_clr
      && 18'(ranged_travel) <= g_ta[1].clr_lvl) |=> travel_alert[1])
      else $error("low travel alert cleared inside its deadband");

   // Travel deviation
   logic signed [16:0] ddiff;
   logic [16:0]        dmag;
   vts_pkg::vts_pct_t  dev_pt;
   logic [5:0]         dev_t;
   logic [19:0]        dev_ticks;
   logic [19:0]        dev_cnt_q;

   assign ddiff     = 17'(analog_target) - 17'(ranged_travel);
   assign dmag      = ddiff[16] ? 17'(-ddiff) : 17'(ddiff);
   assign dev_pt    = sat(dev_point, vts_pkg::PCT_ZERO, vts_pkg::PCT_FULL);
   assign dev_t     = (dev_time_s < vts_pkg::DEV_T_MIN) ? vts_pkg::DEV_T_MIN
                    : ((dev_time_s > vts_pkg::DEV_T_MAX) ? vts_pkg::DEV_T_MAX : dev_time_s);
   assign dev_ticks = 20'(dev_t) * 20'(vts_pkg::TICKS_PER_S);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dev_cnt_q   <= 20'h00000;
         dev_alert_q <= 1'b0;
      end else if (sync_clr) begin
         dev_cnt_q   <= 20'h00000;
         dev_alert_q <= 1'b0;
      end else if (tick_q) begin
         if (dmag > 17'(dev_pt)) begin
            if (dev_cnt_q < dev_ticks) begin
               dev_cnt_q <= dev_cnt_q + 20'h00001;
            end else begin
               dev_alert_q <= 1'b1;
            end
         end else begin
            dev_cnt_q <= 20'h00000;
            if (dmag < 17'(dev_pt)) begin
               dev_alert_q <= 1'b0;
            end
         end
      end
   end
   a_dev_delay: assert property ($rose(dev_alert_q) |-> $past(dev_cnt_q) >= dev_ticks)
      else $error("deviation alert before the deviation time ran out");
   a_sync_clear: assert property (sync_clr |=> (!dev_alert_q && !acc_alert_q
      && travel_alert == 4'h0 && dev_cnt_q == 20'h00000))
      else $error("synchronous clear left alert or timer state");

endmodule

// ===== sim/tb_valve_travel_supervisor.sv
// Self-checking bench for the valve travel supervisor
`timescale 1ns/100ps
module tb_valve_travel_supervisor;
   localparam int TK = 5;
   logic              clock, nrst, sync_clr, acc_clear, addr_wr, hart_rev7, oos_req, ins_req;
   logic              req_secondary, zero_power_position, force_en, cutoff_active_q, in_service_q;
   logic              point_to_point_q, acc_alert_q, dev_alert_q, e_aa;
   logic [5:0]        addr_in, dev_time_s, poll_addr_q, e_addr;
   logic [7:0]        lag_time_s;
   logic [8:0]        open_time_s, close_time_s;
   logic [31:0]       acc_alert_pt, rnd;
   logic [39:0]       accum_q, e_acc;
   logic [3:0]        travel_alert, e_ta;
   vts_pkg::vts_pct_t ranged_travel, analog_target, limit_lo, limit_hi, cutoff_lo, cutoff_hi, acc_deadband;
   vts_pkg::vts_pct_t ta_hi_pt, ta_lo_pt, ta_hihi_pt, ta_lolo_pt, ta_deadband, dev_point, drive_q;
   vts_pkg::vts_pct_t force_val, ref_t, t, d, held;
   int                n_fail, samples_checked;

   vts_supervisor #(.TICK_CYCLES(TK)) DUT (.clock, .nrst, .ranged_travel, .analog_target, .sync_clr,
      .acc_clear, .addr_wr, .addr_in, .hart_rev7, .oos_req, .ins_req, .req_secondary, .lag_time_s,
      .open_time_s, .close_time_s, .limit_lo, .limit_hi, .cutoff_lo, .cutoff_hi, .zero_power_position,
      .acc_deadband, .acc_alert_pt, .ta_hi_pt, .ta_lo_pt, .ta_hihi_pt, .ta_lolo_pt, .ta_deadband,
      .dev_point, .dev_time_s, .drive_q, .cutoff_active_q, .in_service_q, .poll_addr_q,
      .point_to_point_q, .accum_q, .acc_alert_q, .travel_alert, .dev_alert_q);
   vts_valve_model valve (.clock, .nrst, .drive_q, .force_en, .force_val, .ranged_travel);

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Hysteresis: bits 0 and 2 watch the high side, bits 1 and 3 the low side
   function automatic logic [3:0] ta_next(input logic [3:0] s, input vts_pkg::vts_pct_t v);
      vts_pkg::vts_pct_t p[4];
      logic [3:0]        n;
      logic              hi;
      p = '{ta_hi_pt, ta_lo_pt, ta_hihi_pt, ta_lolo_pt};
      n = s;
      for (int i = 0; i < 4; i++) begin
         hi = (i % 2) == 0;
         if (hi ? v > p[i] : v < p[i]) n[i] = 1'b1;
         else if (hi ? v < p[i] - ta_deadband : v > p[i] + ta_deadband) n[i] = 1'b0;
      end
      return n;
   endfunction

   // Range compare; an unknown never lands inside the range
   task automatic rng(input logic signed [39:0] got, lo, hi, input string what);
      samples_checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_fail++;
         $display("FAIL %0t %s got %0d", $time, what, got);
      end
   endtask

   task automatic eq(input logic signed [39:0] got, exp, input string what);
      rng(got, exp, exp, what);
   endtask

   task automatic tk(input int n);
      repeat (n * TK) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic wr_addr(input logic [5:0] a, input logic r7);
      @(posedge clock);
      addr_wr <= 1'b1;
      addr_in <= a;
      hart_rev7 <= r7;
      if (a <= (r7 ? 6'h3F : 6'h0F)) e_addr = a;
      @(posedge clock);
      addr_wr <= 1'b0;
      @(negedge clock);
      eq(poll_addr_q, e_addr, "poll address");
      eq(point_to_point_q, e_addr == 6'h00, "point to point");
   endtask

   task automatic mode(input logic oos, input logic sec, input logic exp);
      @(posedge clock);
      oos_req <= oos;
      ins_req <= !oos;
      req_secondary <= sec;
      @(posedge clock);
      oos_req <= 1'b0;
      ins_req <= 1'b0;
      @(negedge clock);
      eq(in_service_q, exp, "service mode");
   endtask

   task automatic final_report;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      n_fail = 0;
      samples_checked = 0;
      rnd = 32'h13DF374E;
      nrst = 1'b0;
      {sync_clr, acc_clear, addr_wr, hart_rev7, oos_req, ins_req, req_secondary} = '0;
      {zero_power_position, force_en, addr_in, lag_time_s, open_time_s, close_time_s} = '0;
      {limit_lo, force_val} = '0;
      limit_hi = 16'sh2710;
      cutoff_lo = 16'shF63C;
      cutoff_hi = 16'sh30D4;
      acc_deadband = 16'sh01F4;
      acc_alert_pt = 32'h000001F4;
      ta_hi_pt = 16'sh1F40;
      ta_lo_pt = 16'sh07D0;
      ta_hihi_pt = 16'sh2328;
      ta_lolo_pt = 16'sh03E8;
      ta_deadband = 16'sh00C8;
      dev_point = 16'sh2710;
      // Zero deviation time must behave as the one second minimum
      dev_time_s = 6'h00;
      analog_target = 16'sh1388;
      e_addr = 6'h00;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      @(negedge clock);
      eq(drive_q, 16'sh0000, "reset drive");
      eq({in_service_q, point_to_point_q, poll_addr_q}, 8'hC0, "reset mode");
      eq(accum_q, 40'h0, "reset accumulator");
      eq({cutoff_active_q, acc_alert_q, travel_alert, dev_alert_q}, 7'h00, "reset alerts");
      wr_addr(6'h05, 1'b0);
      wr_addr(6'h0F, 1'b0);
      wr_addr(6'h10, 1'b0);
      wr_addr(6'h3F, 1'b1);
      wr_addr(6'h00, 1'b1);
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         wr_addr(rnd[5:0], rnd[6]);
      end
      @(posedge clock);
      limit_lo <= 16'sh03E8;
      limit_hi <= 16'sh1B58;
      analog_target <= 16'sh2328;
      tk(4);
      eq(drive_q, 16'sh1B58, "clamp high");
      @(posedge clock);
      analog_target <= 16'shFE0C;
      tk(4);
      eq(drive_q, 16'sh03E8, "clamp low");
      mode(1'b1, 1'b0, 1'b0);
      held = drive_q;
      @(posedge clock);
      analog_target <= 16'sh0BB8;
      tk(4);
      eq(drive_q, held, "frozen out of service");
      mode(1'b0, 1'b1, 1'b0);
      mode(1'b1, 1'b1, 1'b0);
      mode(1'b0, 1'b1, 1'b0);
      mode(1'b0, 1'b0, 1'b1);
      mode(1'b1, 1'b1, 1'b0);
      mode(1'b0, 1'b0, 1'b0);
      mode(1'b0, 1'b1, 1'b1);
      tk(3);
      eq(drive_q, 16'sh0BB8, "resumed");
      @(posedge clock);
      limit_lo <= 16'sh0000;
      limit_hi <= 16'sh2710;
      open_time_s <= 9'h002;
      analog_target <= 16'sh1388;
      tk(400);
      rng(drive_q, 16'sh0C7D, 16'sh0C83, "opening rate");
      @(posedge clock);
      open_time_s <= 9'h000;
      close_time_s <= 9'h001;
      analog_target <= 16'sh0000;
      tk(100);
      // Opening is now unlimited, so the stage first catches the stale 50 % target, then falls a count a tick
      rng(drive_q, 16'sh1323, 16'sh1329, "closing rate");
      @(posedge clock);
      close_time_s <= 9'h000;
      analog_target <= 16'sh03E8;
      tk(3);
      eq(drive_q, 16'sh03E8, "rate off");
      @(posedge clock);
      lag_time_s <= 8'h01;
      analog_target <= 16'sh1770;
      tk(100);
      rng(drive_q, 16'sh0410, 16'sh0424, "lag filter");
      @(posedge clock);
      lag_time_s <= 8'h00;
      tk(3);
      eq(drive_q, 16'sh1770, "lag bypass");
      @(posedge clock);
      cutoff_lo <= 16'sh01F4;
      cutoff_hi <= 16'sh251C;
      force_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         zero_power_position <= i[0];
         force_val <= i[1] ? 16'sh2648 : 16'sh00C8;
         tk(1);
         eq(drive_q, (i[0] ^ i[1]) ? 16'sh2710 : 16'sh0000, "cutoff drive");
         eq(cutoff_active_q, 1'b1, "cutoff flag");
      end
      // Zero deadband first so the reference is known before counting starts
      @(posedge clock);
      cutoff_lo <= 16'shF63C;
      cutoff_hi <= 16'sh30D4;
      zero_power_position <= 1'b0;
      force_val <= 16'sh1388;
      acc_deadband <= 16'sh0000;
      tk(3);
      @(posedge clock);
      acc_deadband <= 16'sh01F4;
      acc_clear <= 1'b1;
      sync_clr <= 1'b1;
      @(posedge clock);
      acc_clear <= 1'b0;
      sync_clr <= 1'b0;
      ref_t = 16'sh1388;
      e_acc = '0;
      e_ta = '0;
      e_aa = 1'b0;
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         t = vts_pkg::vts_pct_t'(rnd % 32'h00002711);
         if (i % 4 == 3) t = (ref_t > 16'sh1B58) ? ref_t - 16'sh01F4 : ref_t + 16'sh01F4;
         d = (t > ref_t) ? t - ref_t : ref_t - t;
         if (d > 16'sh01F4) begin
            e_acc = e_acc + 40'(d);
            ref_t = t;
         end
         e_ta = ta_next(e_ta, t);
         if (e_acc > 40'(acc_alert_pt) * 40'h64) e_aa = 1'b1;
         else if (e_acc < 40'(acc_alert_pt) * 40'h64) e_aa = 1'b0;
         @(posedge clock);
         force_val <= t;
         tk(3);
         eq(accum_q, e_acc, "accumulator");
         eq(acc_alert_q, e_aa, "accumulator alert");
         eq(travel_alert, e_ta, "travel alerts");
      end
      @(posedge clock);
      acc_clear <= 1'b1;
      @(posedge clock);
      acc_clear <= 1'b0;
      tk(1);
      eq(accum_q, 40'h0, "accumulator cleared");
      eq(acc_alert_q, 1'b0, "accumulator alert cleared");
      @(posedge clock);
      dev_point <= 16'sh01F4;
      force_val <= 16'sh1B58;
      tk(9995);
      eq(dev_alert_q, 1'b0, "deviation early");
      tk(10);
      eq(dev_alert_q, 1'b1, "deviation alert");
      @(posedge clock);
      force_val <= 16'sh189C;
      tk(2);
      eq(dev_alert_q, 1'b0, "deviation cleared");
      final_report();
   end

   initial begin
      repeat (80000) @(posedge clock);
      n_fail++;
      final_report();
   end
endmodule

// ===== sim/vts_valve_model.sv
// Behavioural valve stem and travel sensor driven by the supervisor
`timescale 1ns/100ps
module vts_valve_model (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              nrst,
   // Drive in, travel out
   input  wire vts_pkg::vts_pct_t drive_q,
   input  wire logic              force_en,
   input  wire vts_pkg::vts_pct_t force_val,
   output vts_pkg::vts_pct_t      ranged_travel
);
   vts_pkg::vts_pct_t pos_q;
   // Stem slews a fixed step a clock; friction is not modelled, so travel never overshoots
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pos_q <= 16'sh0000;
      end else if (pos_q < drive_q - 16'sh0028) begin
         pos_q <= pos_q + 16'sh0028;
      end else if (pos_q > drive_q + 16'sh0028) begin
         pos_q <= pos_q - 16'sh0028;
      end else begin
         pos_q <= drive_q;
      end
   end
   // Bench may pin the stem to stage a stuck valve or a cutoff
   assign ranged_travel = force_en ? force_val : pos_q;
endmodule
